// File: logic/status_reporting_registers.sv
// status reporting registers: operation, standard event and status byte structure with error queue.
// assumes a front end that delivers decoded commands and takes response characters.
module status_reporting_registers (
	input  wire logic        clock,        // 200 MHz system clock
	input  wire logic        rstn,         // asynchronous reset, active low
	input  wire logic        cmd_valid,    // decoded command present
	output logic             cmd_ready,    // command taken this cycle
	input  wire logic [3:0]  cmd_code,     // command code
	input  wire logic [15:0] cmd_value,    // parameter of a write
	output logic             resp_valid,   // response character present
	output logic      [7:0]  resp_char,    // response character
	input  wire logic        resp_ready,   // response character taken
	input  wire logic        meas_done,    // measurement finished pulse
	input  wire logic        sweep_done,   // list sweep finished pulse
	input  wire logic        corr_done,    // correction data finished pulse
	input  wire logic        meas_busy,    // measurement in progress
	input  wire logic        sweep_busy,   // sweep in progress
	input  wire logic        corr_busy,    // correction data in progress
	input  wire logic        ops_pending,  // operations still pending
	input  wire logic [7:0]  std_events,   // standard event pulses, bit per event
	input  wire logic        err_push,     // error detected pulse
	input  wire logic [15:0] err_code,     // code of that error
	output logic             service_req,  // service request toward controller
	output logic      [7:0]  status_byte   // live status byte
);

	// ****************************************
	// registers
	// ****************************************
	logic [15:0] oper_event_q, oper_event_d;  // operation event, sticky
	logic [15:0] oper_enab_q;                 // operation enable mask
	logic [7:0]  std_event_q, std_event_d;    // standard event status, sticky
	logic [7:0]  std_enab_q;                  // standard event enable mask
	logic [7:0]  srq_enab_q;                  // service request enable mask
	logic        opc_armed_q;                 // waiting for pending operations
	logic        err_wait_q;                  // error query waiting for queue data
	logic [15:0] query_value;                 // value selected for a query
	wire  [15:0] err_rd_code;                 // oldest error code
	wire  [2:0]  err_count;                   // error entries held
	wire         fmt_busy;                    // formatter sending

	// ****************************************
	// command decode
	// ****************************************
	assign cmd_ready = !fmt_busy && !err_wait_q;
	wire accept       = cmd_valid && cmd_ready;
	wire is_oper_ev_q = accept && (cmd_code == status_pkg::CMD_OPER_EVENT_Q);
	wire is_std_ev_q  = accept && (cmd_code == status_pkg::CMD_STD_EVENT_Q);
	wire is_clear     = accept && (cmd_code == status_pkg::CMD_CLEAR_STATUS);
	wire is_oper_enab = accept && (cmd_code == status_pkg::CMD_OPER_ENAB);
	wire is_std_enab  = accept && (cmd_code == status_pkg::CMD_STD_ENAB);
	wire is_srq_enab  = accept && (cmd_code == status_pkg::CMD_SRQ_ENAB);
	wire is_arm_opc   = accept && (cmd_code == status_pkg::CMD_OP_COMPLETE);
	wire is_err_q     = accept && (cmd_code == status_pkg::CMD_ERROR_Q);
	wire is_ident_q   = accept && (cmd_code == status_pkg::CMD_IDENT_Q);
	wire is_value_q   = accept && ((cmd_code == status_pkg::CMD_OPER_EVENT_Q) ||
	                    (cmd_code == status_pkg::CMD_OPER_COND_Q) || (cmd_code == status_pkg::CMD_OPER_ENAB_Q) ||
	                    (cmd_code == status_pkg::CMD_STD_ENAB_Q) || (cmd_code == status_pkg::CMD_STD_EVENT_Q) ||
	                    (cmd_code == status_pkg::CMD_SRQ_ENAB_Q) || (cmd_code == status_pkg::CMD_STATUS_Q));

	// ****************************************
	// operation status structure
	// ****************************************
	// condition mirrors activity
	wire [15:0] oper_cond = {11'h000, meas_busy, sweep_busy, 2'b00, corr_busy};
	wire [15:0] oper_set  = {11'h000, meas_done, sweep_done, 2'b00, corr_done};
	// read or clear status empties events; a new event in the same cycle survives
	assign oper_event_d = (oper_event_q & ~{16{is_oper_ev_q || is_clear}}) | oper_set;
	wire oper_summary = |(oper_event_q & oper_enab_q);

	// ****************************************
	// standard event structure
	// ****************************************
	// armed operation complete fires once nothing is pending
	wire opc_fire = opc_armed_q && !ops_pending;
	wire [7:0] std_set = std_events | (8'(opc_fire) << status_pkg::STD_OPC_BIT);
	// read clears, with set winning over clear
	assign std_event_d = (std_event_q & ~{8{is_std_ev_q || is_clear}}) | std_set;
	// standard event summary from enabled events
	wire std_summary = |(std_event_q & std_enab_q);

	// ****************************************
	// status byte and service request
	// ****************************************
	// message available while a response is being sent
	wire mav = fmt_busy;
	// request service from enabled summaries, bit 6 itself excluded
	wire rqs = |({oper_summary, std_summary, mav} &
	             {srq_enab_q[status_pkg::STB_OPER_BIT], srq_enab_q[status_pkg::STB_STD_BIT],
	              srq_enab_q[status_pkg::STB_MAV_BIT]});
	assign status_byte = {oper_summary, rqs, std_summary, mav, 4'h0};
	// request toward controller follows request service
	assign service_req = rqs;

	// ****************************************
	// query value selection
	// ****************************************
	// condition, enable and status byte queries are plain reads
	// status byte query reads, never clears
	always_comb begin
		case (cmd_code)
			status_pkg::CMD_OPER_EVENT_Q: query_value = oper_event_q;
			status_pkg::CMD_OPER_COND_Q:  query_value = oper_cond;
			status_pkg::CMD_OPER_ENAB_Q:  query_value = oper_enab_q;
			status_pkg::CMD_STD_ENAB_Q:   query_value = {8'h00, std_enab_q};
			status_pkg::CMD_STD_EVENT_Q:  query_value = {8'h00, std_event_q};
			status_pkg::CMD_SRQ_ENAB_Q:   query_value = {8'h00, srq_enab_q};
			status_pkg::CMD_STATUS_Q:     query_value = {8'h00, status_byte};
			default:                      query_value = 16'h0000;
		endcase
	end

	// error answer arrives a cycle after the pop; negative codes print with a sign
	wire        err_neg = err_rd_code[15];
	wire [15:0] err_mag = err_neg ? (~err_rd_code + 16'h0001) : err_rd_code;
	wire        fmt_start = is_value_q || is_ident_q || err_wait_q;
	wire [15:0] fmt_mag   = err_wait_q ? err_mag : query_value;

	// ****************************************
	// event registers
	// ****************************************
	// sticky event flags, power-on bit set from reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oper_event_q <= 16'h0000;
			std_event_q  <= status_pkg::STD_RESET_VAL;
		end else begin
			oper_event_q <= oper_event_d;
			std_event_q  <= std_event_d;
		end
	end

	// ****************************************
	// enable masks
	// ****************************************
	// operation and service request masks keep only bits that exist, unused positions read zero; standard event mask keeps all eight
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oper_enab_q <= 16'h0000;
			std_enab_q  <= 8'h00;
			srq_enab_q  <= 8'h00;
		end else begin
			if (is_oper_enab) oper_enab_q <= cmd_value & status_pkg::OPER_USED_MASK;
			if (is_std_enab) std_enab_q <= cmd_value[7:0];
			// service request enable write, request bit cannot enable itself
			if (is_srq_enab) srq_enab_q <= cmd_value[7:0] & status_pkg::SRE_USED_MASK;
		end
	end

	// ****************************************
	// sequencing flags
	// ****************************************
	// operation complete arming and error query wait
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			opc_armed_q <= 1'b0;
			err_wait_q  <= 1'b0;
		end else begin
			// clear status drops a pending arm as well
			if (is_arm_opc) opc_armed_q <= 1'b1;
			else if (opc_fire || is_clear) opc_armed_q <= 1'b0;
			err_wait_q <= is_err_q;
		end
	end

	// ****************************************
	// sub-blocks
	// ****************************************
	// five-entry error queue, flushed by clear status
	error_queue u_errq (
		.clock     (clock),
		.rstn      (rstn),
		.push      (err_push),
		.push_code (err_code),
		.pop       (is_err_q),
		.flush     (is_clear),
		.rd_code_q (err_rd_code),
		.count_q   (err_count)
	);

	// decimal answers with terminator, identity text
	response_formatter u_fmt (
		.clock      (clock),
		.rstn       (rstn),
		.start      (fmt_start),
		.text       (is_ident_q),
		.magnitude  (fmt_mag),
		.negative   (err_wait_q && err_neg),
		.busy       (fmt_busy),
		.out_valid  (resp_valid),
		.out_char_q (resp_char),
		.out_ready  (resp_ready)
	);

	// ****************************************
	// checks
	// ****************************************
	oper_reserved_a: assert property (@(posedge clock) disable iff (!rstn)
		(oper_event_q & ~status_pkg::OPER_USED_MASK) == 16'h0000)
		else $error("operation event reserved bit set");

	oper_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		is_oper_ev_q && !meas_done && !sweep_done && !corr_done |=> oper_event_q == 16'h0000)
		else $error("operation event not cleared by read");

	oper_cond_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(meas_busy) |-> oper_cond[status_pkg::OPER_MEAS_BIT] && !oper_cond[1])
		else $error("condition does not follow measuring");

	cond_keep_a: assert property (@(posedge clock) disable iff (!rstn)
		accept && cmd_code == status_pkg::CMD_OPER_COND_Q
		|=> oper_event_q == ($past(oper_event_q) | $past(oper_set)))
		else $error("condition read disturbed events");

	clear_all_a: assert property (@(posedge clock) disable iff (!rstn)
		is_clear && !err_push |=> err_count == 3'h0 && std_event_q == $past(std_set)
		&& oper_event_q == $past(oper_set))
		else $error("clear status left state behind");

	std_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		is_std_ev_q ##1 (std_events == 8'h00 && !opc_fire) |-> std_event_q == $past(std_set))
		else $error("standard event not cleared by read");

	stb_nibble_a: assert property (@(posedge clock) disable iff (!rstn)
		status_byte[3:0] == 4'h0 && status_byte[status_pkg::STB_MAV_BIT] == resp_valid)
		else $error("status byte layout wrong");

	stb_keep_a: assert property (@(posedge clock) disable iff (!rstn)
		accept && cmd_code == status_pkg::CMD_STATUS_Q && std_events == 8'h00 && !opc_fire && !err_push
		|=> std_event_q == $past(std_event_q))
		else $error("status byte read changed state");

	opc_set_a: assert property (@(posedge clock) disable iff (!rstn)
		opc_armed_q && !ops_pending && !is_clear && !is_arm_opc
		|=> std_event_q[status_pkg::STD_OPC_BIT] && !opc_armed_q)
		else $error("operation complete bit not set");

	errq_bound_a: assert property (@(posedge clock) disable iff (!rstn)
		err_count <= 3'(status_pkg::ERRQ_DEPTH))
		else $error("error queue count beyond depth");

	srq_rel_a: assert property (@(posedge clock) disable iff (!rstn)
		service_req == (|({status_byte[7], status_byte[5:4]} & {srq_enab_q[7], srq_enab_q[5:4]})))
		else $error("service request mismatch");

	oper_mask_a: assert property (@(posedge clock) disable iff (!rstn)
		is_oper_enab |=> oper_enab_q == ($past(cmd_value) & status_pkg::OPER_USED_MASK))
		else $error("operation enable mask not stored");

	std_mask_a: assert property (@(posedge clock) disable iff (!rstn)
		is_std_enab |=> {8'h00, std_enab_q} == ($past(cmd_value) & 16'h00FF))
		else $error("standard event enable mask not stored");

	srq_mask_a: assert property (@(posedge clock) disable iff (!rstn)
		is_srq_enab |=> {8'h00, srq_enab_q} == ($past(cmd_value) & {8'h00, status_pkg::SRE_USED_MASK}))
		else $error("service request enable mask not stored");

endmodule // status_reporting_registers

// File: logic/status_pkg.sv
// status reporting package: command codes, bit positions, reset values, text constants.
// assumes one clock domain and a command front end that delivers decoded commands.
package status_pkg;

	// ****************************************
	// command codes from the front end
	// ****************************************
	localparam logic [3:0] CMD_OPER_EVENT_Q = 4'h0;  // operation event query, clears
	localparam logic [3:0] CMD_OPER_COND_Q  = 4'h1;  // operation condition query
	localparam logic [3:0] CMD_OPER_ENAB    = 4'h2;  // operation enable write
	localparam logic [3:0] CMD_OPER_ENAB_Q  = 4'h3;  // operation enable query
	localparam logic [3:0] CMD_CLEAR_STATUS = 4'h4;  // clear status
	localparam logic [3:0] CMD_STD_ENAB     = 4'h5;  // standard event enable write
	localparam logic [3:0] CMD_STD_ENAB_Q   = 4'h6;  // standard event enable query
	localparam logic [3:0] CMD_STD_EVENT_Q  = 4'h7;  // standard event status query, clears
	localparam logic [3:0] CMD_SRQ_ENAB     = 4'h8;  // service request enable write
	localparam logic [3:0] CMD_SRQ_ENAB_Q   = 4'h9;  // service request enable query
	localparam logic [3:0] CMD_STATUS_Q     = 4'hA;  // status byte query
	localparam logic [3:0] CMD_IDENT_Q      = 4'hB;  // identification query
	localparam logic [3:0] CMD_OP_COMPLETE  = 4'hC;  // arm operation complete
	localparam logic [3:0] CMD_ERROR_Q      = 4'hD;  // error queue query, pops

	// ****************************************
	// operation register bits
	// ****************************************
	localparam int            OPER_MEAS_BIT  = 4;         // measurement
	localparam int            OPER_SWEEP_BIT = 3;         // list sweep
	localparam int            OPER_CORR_BIT  = 0;         // correction data
	localparam logic [15:0]   OPER_USED_MASK = 16'h0019;  // bits that can ever be set

	// ****************************************
	// standard event and status byte bits
	// ****************************************
	localparam int          STD_OPC_BIT   = 0;      // operation complete
	localparam logic [7:0]  STD_RESET_VAL = 8'h80;  // power-on bit set after reset
	localparam int          STB_OPER_BIT  = 7;      // operation summary
	localparam int          STB_RQS_BIT   = 6;      // request service
	localparam int          STB_STD_BIT   = 5;      // standard event summary
	localparam int          STB_MAV_BIT   = 4;      // message available
	localparam logic [7:0]  SRE_USED_MASK = 8'hB0;  // enable bits that take part in service request

	// ****************************************
	// error queue
	// ****************************************
	localparam int           ERRQ_DEPTH    = 5;         // entries
	localparam logic [15:0]  ERRQ_OVERFLOW = 16'hFEA2;  // -350 in two's complement

	// ****************************************
	// response text
	// ****************************************
	localparam logic [7:0]   CHAR_TERM  = 8'h0A;  // message terminator
	localparam logic [7:0]   CHAR_MINUS = 8'h2D;  // minus sign
	localparam logic [7:0]   CHAR_ZERO  = 8'h30;  // ascii zero
	localparam int           IDENT_LEN  = 20;     // identity string length
	// identity string is arbitrary: maker, model, serial 0, firmware revision
	localparam logic [8*IDENT_LEN-1:0] IDENT_TEXT = "MAKER,MODEL,0,REV1.0";

endpackage

// File: logic/error_queue.sv
// error queue: five-entry first-in first-out store with overflow marker.
// assumes pushes and pops arrive as single-cycle pulses on the common clock.
module error_queue (
	input  wire logic        clock,     // system clock
	input  wire logic        rstn,      // asynchronous reset, active low
	input  wire logic        push,      // new error pulse
	input  wire logic [15:0] push_code, // error code
	input  wire logic        pop,       // read and remove oldest
	input  wire logic        flush,     // empty the queue
	output logic      [15:0] rd_code_q, // oldest code at the last pop, zero if that pop found the queue empty
	output logic      [2:0]  count_q    // entries held
);

	// ****************************************
	// storage and pointers
	// ****************************************
	logic [15:0] mem_q [status_pkg::ERRQ_DEPTH];  // entries
	logic [2:0]  rd_ptr_q;                        // oldest entry
	logic [2:0]  wr_ptr_q;                        // next free slot
	wire         empty   = (count_q == 3'h0);
	wire         full    = (count_q == 3'(status_pkg::ERRQ_DEPTH));
	wire         do_pop  = pop && !empty;
	// a full queue keeps its oldest entries; the newest slot becomes the overflow marker
	wire         do_wr   = push && (!full || do_pop);
	wire         do_ovf  = push && full && !do_pop;
	wire [2:0]   last_ptr = (wr_ptr_q == 3'h0) ? 3'(status_pkg::ERRQ_DEPTH - 1) : wr_ptr_q - 3'h1;

	function automatic logic [2:0] wrap_inc(input logic [2:0] p);
		wrap_inc = (p == 3'(status_pkg::ERRQ_DEPTH - 1)) ? 3'h0 : p + 3'h1;
	endfunction

	// write port, no reset needed on the data array
	always_ff @(posedge clock) begin
		if (do_wr) begin
			mem_q[wr_ptr_q] <= push_code;
		end else if (do_ovf) begin
			mem_q[last_ptr] <= status_pkg::ERRQ_OVERFLOW;
		end
	end

	ovf_mark_a: assert property (@(posedge clock) disable iff (!rstn)
		do_ovf |=> mem_q[$past(last_ptr)] == status_pkg::ERRQ_OVERFLOW)
		else $error("overflow marker missing");

	// pointers, count and registered read data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_ptr_q  <= 3'h0;
			wr_ptr_q  <= 3'h0;
			count_q   <= 3'h0;
			rd_code_q <= 16'h0000;
		end else if (flush) begin
			rd_ptr_q  <= 3'h0;
			wr_ptr_q  <= 3'h0;
			count_q   <= 3'h0;
			rd_code_q <= 16'h0000;
		end else begin
			if (pop) begin
				rd_code_q <= empty ? 16'h0000 : mem_q[rd_ptr_q];
			end
			if (do_pop) begin
				rd_ptr_q <= wrap_inc(rd_ptr_q);
			end
			if (do_wr) begin
				wr_ptr_q <= wrap_inc(wr_ptr_q);
			end
			count_q <= count_q + {2'b00, do_wr} - {2'b00, do_pop};
		end
	end

endmodule // error_queue

// File: logic/response_formatter.sv
// response formatter: turns a value into decimal ascii plus terminator, or sends the identity text.
// assumes the receiver takes a character whenever out_valid and out_ready are both high.
module response_formatter (
	input  wire logic        clock,      // system clock
	input  wire logic        rstn,       // asynchronous reset, active low
	input  wire logic        start,      // begin a response, only while idle
	input  wire logic        text,       // send identity text instead of a number
	input  wire logic [15:0] magnitude,  // number magnitude
	input  wire logic        negative,   // prefix a minus sign
	output logic             busy,       // response in progress
	output logic             out_valid,  // character available
	output logic      [7:0]  out_char_q, // character
	input  wire logic        out_ready   // character taken
);

	typedef enum logic [4:0] {
		F_IDLE  = 5'b00001,
		F_SIGN  = 5'b00010,
		F_DIGIT = 5'b00100,
		F_TERM  = 5'b01000,
		F_TEXT  = 5'b10000
	} fmt_state_e;

	fmt_state_e  state_q, state_d;  // kind of the character on show
	logic [15:0] value_q;           // number being sent
	logic [4:0]  idx_q, idx_d;      // digit position or text index

	// one decimal digit of a value
	function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [4:0] i);
		logic [15:0] q;
		q = v;
		case (i)
			5'h4:    q = v / 16'd10000;
			5'h3:    q = v / 16'd1000;
			5'h2:    q = v / 16'd100;
			5'h1:    q = v / 16'd10;
			default: q = v;
		endcase
		dec_digit = 4'(q % 16'd10);
	endfunction

	// highest nonzero digit position, zero prints as one digit
	function automatic logic [4:0] top_digit(input logic [15:0] v);
		top_digit = (v >= 16'd10000) ? 5'h4 : (v >= 16'd1000) ? 5'h3 :
		            (v >= 16'd100) ? 5'h2 : (v >= 16'd10) ? 5'h1 : 5'h0;
	endfunction

	function automatic logic [7:0] char_of(input fmt_state_e s, input logic [15:0] v, input logic [4:0] i);
		case (s)
			F_SIGN:  char_of = status_pkg::CHAR_MINUS;
			F_DIGIT: char_of = status_pkg::CHAR_ZERO + {4'h0, dec_digit(v, i)};
			F_TEXT:  char_of = status_pkg::IDENT_TEXT[8*(status_pkg::IDENT_LEN - 1 - int'(i)) +: 8];
			default: char_of = status_pkg::CHAR_TERM;
		endcase
	endfunction

	assign busy      = (state_q != F_IDLE);
	assign out_valid = busy;
	wire   take      = out_valid && out_ready;
	wire [15:0] value_use = start ? magnitude : value_q;

	// next character selection
	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		if (start && !busy) begin
			state_d = text ? F_TEXT : (negative ? F_SIGN : F_DIGIT);
			idx_d   = text ? 5'h0 : top_digit(magnitude);
		end else if (take) begin
			case (state_q)
				F_SIGN:  state_d = F_DIGIT;
				F_DIGIT: begin
					state_d = (idx_q == 5'h0) ? F_TERM : F_DIGIT;
					idx_d   = idx_q - 5'h1;
				end
				F_TEXT:  begin
					state_d = (idx_q == 5'(status_pkg::IDENT_LEN - 1)) ? F_TERM : F_TEXT;
					idx_d   = idx_q + 5'h1;
				end
				default: state_d = F_IDLE;
			endcase
		end
	end

	// state and character registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q    <= F_IDLE;
			idx_q      <= 5'h0;
			value_q    <= 16'h0000;
			out_char_q <= 8'h00;
		end else begin
			state_q    <= state_d;
			idx_q      <= idx_d;
			value_q    <= value_use;
			out_char_q <= char_of(state_d, value_use, idx_d);
		end
	end

endmodule // response_formatter

// File: bench/response_sink.sv
// response sink: controller side that takes response characters
// assumes characters are offered by valid and ready on the common clock
module response_sink (
	input  wire logic       clock,      // system clock
	input  wire logic       slow,       // stall every other cycle
	input  wire logic       resp_valid, // character offered
	input  wire logic [7:0] resp_char,  // character
	output logic            resp_ready  // character taken
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [167:0] got_q = '0; // newest character lowest, bench clears it
	initial resp_ready = 1'b0;
	// ready moves off the sampling edge; a slow controller tests the stall path
	always @(negedge clock) resp_ready <= slow ? !resp_ready : 1'b1;
	always @(posedge clock) if (resp_valid && resp_ready) got_q <= {got_q[159:0], resp_char};
endmodule // response_sink

// File: bench/testbench.sv
// testbench: command sequences with expected answers
// assumes the design and response sink from this tree
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0, rstn = 1'b0, slow = 1'b0, cmd_valid = 1'b0;
	logic meas_done, sweep_done, corr_done, meas_busy, sweep_busy, corr_busy, ops_pending, err_push;
	logic [3:0] cmd_code;
	logic [15:0] cmd_value, err_code;
	logic [7:0] std_events, resp_char, status_byte;
	logic cmd_ready, resp_valid, resp_ready, service_req;
	int mismatches = 0, compares = 0, i;
	always #2.5 clock = !clock;
	status_reporting_registers status_reporting_registers_inst (.clock(clock), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_value(cmd_value),
		.resp_valid(resp_valid), .resp_char(resp_char), .resp_ready(resp_ready), .meas_done(meas_done),
		.sweep_done(sweep_done), .corr_done(corr_done), .meas_busy(meas_busy), .sweep_busy(sweep_busy),
		.corr_busy(corr_busy), .ops_pending(ops_pending), .std_events(std_events), .err_push(err_push),
		.err_code(err_code), .service_req(service_req), .status_byte(status_byte));
	response_sink response_sink_inst (.clock(clock), .slow(slow), .resp_valid(resp_valid),
		.resp_char(resp_char), .resp_ready(resp_ready));
	// ****
	// shared tasks
	// ****
	task check(input logic [167:0] seen, input logic [167:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one command, held until taken, then wait for its answer to finish
	task send(input logic [3:0] c, input logic [15:0] v);
		int n;
		@(negedge clock);
		response_sink_inst.got_q = '0;
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_value = v;
		// ready is settled at the falling edge, so the next rising edge takes the command once
		for (n = 0; n < 50 && cmd_ready !== 1'b1; n++) @(negedge clock);
		@(posedge clock);
		@(negedge clock);
		cmd_valid = 1'b0;
		for (n = 0; n < 400 && !(cmd_ready === 1'b1 && resp_valid === 1'b0); n++) @(negedge clock);
	endtask
	task query(input logic [3:0] c, input logic [159:0] t);
		send(c, 16'h0000);
		check(response_sink_inst.got_q, {t, 8'h0A});
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	initial begin
		#20000;
		mismatches++;
		summarize;
	end
	initial begin
		{meas_done, sweep_done, corr_done, meas_busy, sweep_busy, corr_busy, ops_pending, err_push} = '0;
		{cmd_code, cmd_value, err_code, std_events} = '0;
		repeat (5) @(negedge clock);
		rstn = 1'b1;
		check({service_req, status_byte}, 9'h000);
		query(status_pkg::CMD_STD_EVENT_Q, "128");
		query(status_pkg::CMD_STD_EVENT_Q, "0");
		meas_busy = 1'b1;
		sweep_busy = 1'b1;
		pulse(meas_done);
		pulse(corr_done);
		query(status_pkg::CMD_OPER_COND_Q, "24");
		query(status_pkg::CMD_OPER_COND_Q, "24");
		query(status_pkg::CMD_OPER_EVENT_Q, "17");
		query(status_pkg::CMD_OPER_EVENT_Q, "0");
		send(status_pkg::CMD_OPER_ENAB, 16'hFFFF);
		query(status_pkg::CMD_OPER_ENAB_Q, "25");
		send(status_pkg::CMD_SRQ_ENAB, 16'h00FF);
		query(status_pkg::CMD_SRQ_ENAB_Q, "176");
		pulse(sweep_done);
		check({service_req, status_byte}, 9'h1C0);
		query(status_pkg::CMD_STATUS_Q, "192");
		check({service_req, status_byte}, 9'h1C0);
		send(status_pkg::CMD_STD_ENAB, 16'h0004);
		query(status_pkg::CMD_STD_ENAB_Q, "4");
		@(negedge clock);
		std_events = 8'h04;
		@(negedge clock);
		std_events = 8'h00;
		check({service_req, status_byte}, 9'h1E0);
		send(status_pkg::CMD_CLEAR_STATUS, 16'h0000);
		check({service_req, status_byte}, 9'h000);
		query(status_pkg::CMD_OPER_EVENT_Q, "0");
		ops_pending = 1'b1;
		send(status_pkg::CMD_OP_COMPLETE, 16'h0000);
		query(status_pkg::CMD_STD_EVENT_Q, "0");
		ops_pending = 1'b0;
		repeat (3) @(negedge clock);
		query(status_pkg::CMD_STD_EVENT_Q, "1");
		for (i = 1; i <= 6; i++) begin
			@(negedge clock);
			err_push = 1'b1;
			err_code = i[15:0];
		end
		@(negedge clock);
		err_push = 1'b0;
		for (i = 1; i <= 4; i++) query(status_pkg::CMD_ERROR_Q, 8'h30 + i[7:0]);
		query(status_pkg::CMD_ERROR_Q, "-350");
		query(status_pkg::CMD_ERROR_Q, "0");
		pulse(err_push);
		send(status_pkg::CMD_CLEAR_STATUS, 16'h0000);
		query(status_pkg::CMD_ERROR_Q, "0");
		slow = 1'b1;
		query(status_pkg::CMD_IDENT_Q, status_pkg::IDENT_TEXT);
		summarize;
	end
endmodule // testbench
